//--- shared/bqs_defines.svh
// Function
// - Static clock beyond 30 ns resets loop.
// - Loop-disable rising edge resets loop.
// - Release disable only with stable clock.
// - Wait full lock interval before operations.
// - Frequency change needs a loop reset.
// - Burst walks base, +1, +2, +3.
// - Read and write machines run independently.
// - State advances on both edges of the true clock.
// - Read select low at rise requests read.
// - Write select low at rise requests write.
// - Read words at t+2.5 through t+4.0.
// - Write words at t+2.0 through t+3.5.
// - Same operation on next rise ignored.
// - Read wins when both selects asserted.
// - Writes buffered, committed on third write.
// - Loop locks within 2048 stable cycles.
`ifndef BQS_DEFINES_SVH
`define BQS_DEFINES_SVH
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define BQS_CLK_NS 40
`define BQS_STOP_NS 30
`define BQS_STOP_CYC ((`BQS_STOP_NS + `BQS_CLK_NS - 1) / `BQS_CLK_NS)
`define BQS_LOCK_CYC 2048
`define BQS_STABLE_CYC 16
// ------------------------------------------------------------
// Burst scheduling in clock phases
// ------------------------------------------------------------
`define BQS_BURST 4
`define BQS_PIPE 8
`define BQS_RD_SLOT 4
`define BQS_WR_SLOT 3
`define BQS_CRD_SLOT 6
`define BQS_CPIPE 10
`define BQS_FIFO_D 8
`endif

//--- shared/bqs_pkg.sv
package bqs_pkg;
  typedef enum logic [1:0] {
    DLL_OFF     = 2'b00,
    DLL_LOCKING = 2'b01,
    DLL_LOCKED  = 2'b10
  } bqs_dll_e;
  typedef enum logic [1:0] {
    C_POWER = 2'b00,
    C_LOCK  = 2'b01,
    C_RUN   = 2'b10,
    C_STOP  = 2'b11
  } bqs_ctl_e;
endpackage

//--- shared/bqs_if.sv
`timescale 1ns/1ps
interface bqs_if #(
  parameter int AW = 8,
  parameter int DW = 36
) ();
  logic          k;
  logic          k_n;
  logic          doff_n;
  logic          r_n;
  logic          w_n;
  logic [AW-1:0] a;
  logic [DW-1:0] d;
  logic [DW-1:0] q;
  logic          q_oe;
  modport dev (input k, k_n, doff_n, r_n, w_n, a, d, output q, q_oe);
  modport ctl (output k, k_n, doff_n, r_n, w_n, a, d, input q, q_oe);
endinterface

//--- src/bqs_dev.sv
`timescale 1ns/1ps
`include "bqs_defines.svh"
module bqs_dev #(
  parameter int AW       = 8,
  parameter int DW       = 36,
  parameter int LOCK_CYC = `BQS_LOCK_CYC
) (
  bqs_if.dev        LINK,
  input wire logic  CORE_CLK,
  input wire logic  RST_N,
  output logic      LOCKED,
  output logic      RD_BUSY,
  output logic      WR_BUSY
);
  localparam int LW = $clog2(LOCK_CYC + 1);

  typedef logic [AW-1:0] bqs_addr_t;
  typedef struct packed {
    logic      v;
    bqs_addr_t a;
  } bqs_rslot_s;
  typedef struct packed {
    logic       v;
    logic [1:0] idx;
    bqs_addr_t  a;
  } bqs_wslot_s;
  typedef struct packed {
    logic                            v;
    bqs_addr_t                       a;
    logic [`BQS_BURST-1:0][DW-1:0]   d;
  } bqs_wbuf_s;
  typedef struct packed {
    logic                            k_prev;
    logic                            kn_prev;
    logic                            doff_prev;
    logic [3:0]                      idle;
    bqs_pkg::bqs_dll_e               dll;
    logic [LW-1:0]                   lock_cnt;
    logic                            locked;
    logic                            rd_prev;
    logic                            wr_prev;
    bqs_rslot_s [`BQS_PIPE-1:0]      rp;
    bqs_wslot_s [`BQS_PIPE-1:0]      wp;
    logic [`BQS_BURST-1:0][DW-1:0]   wd;
    bqs_wbuf_s [1:0]                 wb;
    logic [DW-1:0]                   q;
    logic                            q_oe;
    logic                            rd_busy;
    logic                            wr_busy;
  } bqs_dev_s;

  bqs_dev_s      st;
  bqs_dev_s      next_st;
  logic [DW-1:0] mem [2**AW];
  logic          commit;
  bqs_wbuf_s     commit_e;
  logic          clk_edge;
  logic          clk_rise;
  logic          clk_static;
  logic          rd_go;
  logic          wr_go;

  // ------------------------------------------------------------
  // Coherent fetch
  // ------------------------------------------------------------
  // Newer buffered bursts override older ones and the array.
  function automatic logic [DW-1:0] bqs_fetch(input bqs_addr_t wa, input bqs_wbuf_s [1:0] wb);
    logic [DW-1:0] r;
    bqs_addr_t     off;
    r = mem[wa];
    for (int i = 1; i >= 0; i--)
    begin
      off = wa - wb[i].a;
      if (wb[i].v && off < AW'(`BQS_BURST))
      begin
        r = wb[i].d[off[1:0]];
      end
    end
    return r;
  endfunction

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb
  begin
    next_st    = st;
    commit     = 1'b0;
    commit_e   = st.wb[1];
    rd_go      = 1'b0;
    wr_go      = 1'b0;
    clk_edge   = LINK.k != st.k_prev;
    clk_rise   = LINK.k && !st.k_prev;
    clk_static = (LINK.k == st.k_prev) || (LINK.k_n == st.kn_prev);
    next_st.k_prev    = LINK.k;
    next_st.kn_prev   = LINK.k_n;
    next_st.doff_prev = LINK.doff_n;
    if (!clk_static)
    begin
      next_st.idle = '0;
    end
    else if (st.idle != '1)
    begin
      next_st.idle = st.idle + 4'h1;
    end
    if (!LINK.doff_n)
    begin
      next_st.dll    = bqs_pkg::DLL_OFF;
      next_st.locked = 1'b0;
    end
    else if (!st.doff_prev)
    begin
      next_st.dll      = bqs_pkg::DLL_LOCKING;
      next_st.lock_cnt = '0;
      next_st.locked   = 1'b0;
    end
    else if (clk_static && next_st.idle >= 4'(`BQS_STOP_CYC))
    begin
      next_st.dll      = bqs_pkg::DLL_LOCKING;
      next_st.lock_cnt = '0;
      next_st.locked   = 1'b0;
    end
    else if (clk_rise && st.dll == bqs_pkg::DLL_LOCKING)
    begin
      if (st.lock_cnt == LW'(LOCK_CYC - 1))
      begin
        next_st.dll    = bqs_pkg::DLL_LOCKED;
        next_st.locked = 1'b1;
      end
      else
      begin
        next_st.lock_cnt = st.lock_cnt + LW'(1);
      end
    end
    // Everything below moves only with clock phases, so a stopped clock freezes it.
    if (clk_edge)
    begin
      if (st.rp[0].v)
      begin
        next_st.q    = bqs_fetch(st.rp[0].a, st.wb);
        next_st.q_oe = 1'b1;
      end
      else
      begin
        next_st.q_oe = 1'b0;
      end
      if (st.wp[0].v)
      begin
        next_st.wd[st.wp[0].idx] = LINK.d;
        if (st.wp[0].idx == 2'(`BQS_BURST - 1))
        begin
          commit        = st.wb[1].v;
          next_st.wb[1] = st.wb[0];
          next_st.wb[0].v = 1'b1;
          next_st.wb[0].a = st.wp[0].a;
          next_st.wb[0].d = next_st.wd;
        end
      end
      for (int i = 0; i < `BQS_PIPE - 1; i++)
      begin
        next_st.rp[i] = st.rp[i+1];
        next_st.wp[i] = st.wp[i+1];
      end
      next_st.rp[`BQS_PIPE-1] = '0;
      next_st.wp[`BQS_PIPE-1] = '0;
      if (clk_rise)
      begin
        rd_go = !LINK.r_n && !st.rd_prev;
        wr_go = !LINK.w_n && !st.wr_prev && !rd_go;
        next_st.rd_prev = rd_go;
        next_st.wr_prev = wr_go;
        for (int i = 0; i < `BQS_BURST; i++)
        begin
          if (rd_go)
          begin
            next_st.rp[`BQS_RD_SLOT+i].v = 1'b1;
            next_st.rp[`BQS_RD_SLOT+i].a = LINK.a + AW'(i);
          end
          if (wr_go)
          begin
            next_st.wp[`BQS_WR_SLOT+i].v   = 1'b1;
            next_st.wp[`BQS_WR_SLOT+i].idx = 2'(i);
            next_st.wp[`BQS_WR_SLOT+i].a   = LINK.a;
          end
        end
      end
    end
    // Separate pipes let a read and a write burst overlap freely.
    next_st.rd_busy = 1'b0;
    next_st.wr_busy = 1'b0;
    for (int i = 0; i < `BQS_PIPE; i++)
    begin
      next_st.rd_busy = next_st.rd_busy | next_st.rp[i].v;
      next_st.wr_busy = next_st.wr_busy | next_st.wp[i].v;
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      st         <= '0;
      st.kn_prev <= 1'b1;
      st.dll     <= bqs_pkg::DLL_LOCKING;
    end
    else
    begin
      st <= next_st;
    end
  end

  // The array holds no reset; its contents are undefined until written.
  always_ff @(posedge CORE_CLK)
  begin
    if (commit)
    begin
      for (int i = 0; i < `BQS_BURST; i++)
      begin
        mem[commit_e.a + AW'(i)] <= commit_e.d[i];
      end
    end
  end

  assign LINK.q    = st.q;
  assign LINK.q_oe = st.q_oe;
  assign LOCKED    = st.locked;
  assign RD_BUSY   = st.rd_busy;
  assign WR_BUSY   = st.wr_busy;
endmodule

//--- src/bqs_ctl.sv
`timescale 1ns/1ps
`include "bqs_defines.svh"
module bqs_fifo #(
  parameter int W = 36,
  parameter int D = `BQS_FIFO_D
) (
  input wire logic                  clk,
  input wire logic                  rst_n,
  input wire logic                  in_valid,
  output logic                      in_ready,
  input wire logic [W-1:0]          in_data,
  output logic                      out_valid,
  input wire logic                  out_ready,
  output logic [W-1:0]              out_data,
  output logic [$clog2(D+1)-1:0]    level
);
  localparam int PW = $clog2(D);
  localparam int CW = $clog2(D + 1);
  typedef struct packed {
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;
    logic          rdy;
    logic          vld;
  } bqs_fifo_s;
  bqs_fifo_s st;
  bqs_fifo_s next_st;
  logic [W-1:0] mem [D];
  logic push;
  logic pop;

  always_comb
  begin
    next_st = st;
    push    = in_valid && st.rdy;
    pop     = out_ready && st.vld;
    if (push)
    begin
      next_st.wp = (st.wp == PW'(D - 1)) ? '0 : st.wp + PW'(1);
    end
    if (pop)
    begin
      next_st.rp = (st.rp == PW'(D - 1)) ? '0 : st.rp + PW'(1);
    end
    next_st.cnt = st.cnt + CW'(push) - CW'(pop);
    next_st.rdy = next_st.cnt != CW'(D);
    next_st.vld = next_st.cnt != '0;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st     <= '0;
      st.rdy <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[st.wp] <= in_data;
    end
  end

  assign in_ready  = st.rdy;
  assign out_valid = st.vld;
  assign out_data  = mem[st.rp];
  assign level     = st.cnt;
endmodule

module bqs_ctl #(
  parameter int AW         = 8,
  parameter int DW         = 36,
  parameter int LOCK_CYC   = `BQS_LOCK_CYC,
  parameter int STABLE_CYC = `BQS_STABLE_CYC,
  parameter int FIFO_D     = `BQS_FIFO_D
) (
  bqs_if.ctl                LINK,
  input wire logic          CORE_CLK,
  input wire logic          RST_N,
  input wire logic          CMD_VALID,
  input wire logic          CMD_WRITE,
  input wire logic [AW-1:0] CMD_ADDR,
  output logic              RD_READY,
  output logic              WR_READY,
  input wire logic          WD_VALID,
  input wire logic [DW-1:0] WD_DATA,
  output logic              WD_READY,
  output logic [DW-1:0]     RD_DATA,
  output logic              RD_VALID,
  input wire logic          RELOCK,
  output logic              READY
);
  localparam int LW = $clog2(LOCK_CYC + STABLE_CYC + 1);
  localparam int CW = $clog2(FIFO_D + 1);
  typedef struct packed {
    bqs_pkg::bqs_ctl_e       state;
    logic [LW-1:0]           cnt;
    logic                    k;
    logic                    k_n;
    logic                    doff_n;
    logic                    r_n;
    logic                    w_n;
    logic [AW-1:0]           a;
    logic [DW-1:0]           d;
    logic [`BQS_PIPE-1:0]    wp;
    logic [`BQS_CPIPE-1:0]   rp;
    logic                    rd_prev;
    logic                    wr_prev;
    logic                    rd_rdy;
    logic                    wr_rdy;
    logic [DW-1:0]           rdata;
    logic                    rvalid;
    logic                    relock;
    logic                    ready;
  } bqs_ctl_s;
  bqs_ctl_s      st;
  bqs_ctl_s      next_st;
  logic          pop;
  logic [DW-1:0] f_data;
  logic [CW-1:0] f_level;
  logic          acc_rd;
  logic          acc_wr;
  logic          rise;

  bqs_fifo #(.W(DW), .D(FIFO_D)) bqs_fifo_i (
    .clk       (CORE_CLK),
    .rst_n     (RST_N),
    .in_valid  (WD_VALID),
    .in_ready  (WD_READY),
    .in_data   (WD_DATA),
    .out_valid (),
    .out_ready (pop),
    .out_data  (f_data),
    .level     (f_level)
  );

  always_comb
  begin
    next_st        = st;
    next_st.rvalid = 1'b0;
    pop            = st.wp[0];
    rise           = !st.k;
    acc_rd         = 1'b0;
    acc_wr         = 1'b0;
    if (RELOCK)
    begin
      next_st.relock = 1'b1;
    end
    if (st.state != bqs_pkg::C_STOP)
    begin
      next_st.k   = !st.k;
      next_st.k_n = st.k;
    end
    unique case (st.state)
      bqs_pkg::C_POWER:
      begin
        next_st.cnt = st.cnt + LW'(1);
        if (st.cnt == LW'(STABLE_CYC - 1))
        begin
          next_st.doff_n = 1'b1;
          next_st.state  = bqs_pkg::C_LOCK;
          next_st.cnt    = '0;
        end
      end
      bqs_pkg::C_LOCK:
      begin
        if (rise)
        begin
          next_st.cnt = st.cnt + LW'(1);
          if (st.cnt == LW'(LOCK_CYC))
          begin
            next_st.state = bqs_pkg::C_RUN;
          end
        end
      end
      bqs_pkg::C_RUN:
      begin
        // Stopping is deferred until no burst is pending on either port.
        if (st.relock && st.wp == '0 && st.rp == '0 && st.r_n && st.w_n)
        begin
          next_st.state = bqs_pkg::C_STOP;
          next_st.k     = st.k;
          next_st.k_n   = st.k_n;
          next_st.cnt   = '0;
        end
      end
      bqs_pkg::C_STOP:
      begin
        next_st.cnt = st.cnt + LW'(1);
        if (st.cnt == LW'(`BQS_STOP_CYC))
        begin
          next_st.state  = bqs_pkg::C_LOCK;
          next_st.cnt    = '0;
          next_st.relock = 1'b0;
        end
      end
    endcase
    next_st.wp = st.wp >> 1;
    next_st.rp = st.rp >> 1;
    if (st.wp[0])
    begin
      next_st.d = f_data;
    end
    if (st.rp[0])
    begin
      next_st.rdata  = LINK.q;
      next_st.rvalid = 1'b1;
    end
    if (st.state == bqs_pkg::C_RUN && rise)
    begin
      acc_rd = CMD_VALID && !CMD_WRITE && st.rd_rdy;
      acc_wr = CMD_VALID && CMD_WRITE && st.wr_rdy;
      next_st.r_n     = !acc_rd;
      next_st.w_n     = !acc_wr;
      next_st.rd_prev = acc_rd;
      next_st.wr_prev = acc_wr;
      if (acc_rd || acc_wr)
      begin
        next_st.a = CMD_ADDR;
      end
      for (int i = 0; i < `BQS_BURST; i++)
      begin
        if (acc_wr)
        begin
          next_st.wp[`BQS_WR_SLOT+i] = 1'b1;
        end
        if (acc_rd)
        begin
          next_st.rp[`BQS_CRD_SLOT+i] = 1'b1;
        end
      end
    end
    next_st.ready  = next_st.state == bqs_pkg::C_RUN;
    next_st.rd_rdy = next_st.ready && !next_st.k && !next_st.rd_prev && !next_st.relock;
    // Fifo level minus this pop is a safe lower bound for the data a write needs.
    next_st.wr_rdy = next_st.ready && !next_st.k && !next_st.wr_prev && !next_st.relock &&
                     (int'(f_level) - int'(pop) >= `BQS_BURST + $countones(next_st.wp));
  end

  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      st     <= '0;
      st.k_n <= 1'b1;
      st.r_n <= 1'b1;
      st.w_n <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign LINK.k      = st.k;
  assign LINK.k_n    = st.k_n;
  assign LINK.doff_n = st.doff_n;
  assign LINK.r_n    = st.r_n;
  assign LINK.w_n    = st.w_n;
  assign LINK.a      = st.a;
  assign LINK.d      = st.d;
  assign RD_READY    = st.rd_rdy;
  assign WR_READY    = st.wr_rdy;
  assign RD_DATA     = st.rdata;
  assign RD_VALID    = st.rvalid;
  assign READY       = st.ready;
endmodule

//--- verification/bqs_sva.sv
`timescale 1ns/1ps
module bqs_sva #(
  parameter int AW = 8,
  parameter int DW = 36
) (
  input wire logic          CORE_CLK,
  input wire logic          RST_N,
  input wire logic          k,
  input wire logic          k_n,
  input wire logic          doff_n,
  input wire logic          r_n,
  input wire logic          w_n,
  input wire logic [AW-1:0] a,
  input wire logic [DW-1:0] d,
  input wire logic [DW-1:0] q,
  input wire logic          q_oe
);
  // ----------------------------------------
  // Rise detection
  // ----------------------------------------
  logic k_d;
  logic rd_rise;
  logic wr_rise;
  logic k_still;
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
      k_d <= 1'b0;
    else
      k_d <= k;
  end
  assign rd_rise = k & ~k_d & ~r_n;
  assign wr_rise = k & ~k_d & ~w_n;
  // A sample with no change of k counts as a stopped clock.
  assign k_still = (k == k_d);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  sequence s_rd_burst;
    q_oe [*4];
  endsequence
  sequence s_sel_idle;
    (r_n && w_n) [*8];
  endsequence
  property p_rd_window;
    rd_rise |-> ##6 s_rd_burst;
  endproperty
  property p_rd_only;
    q_oe |-> $past(rd_rise, 6) || $past(rd_rise, 7) || $past(rd_rise, 8) || $past(rd_rise, 9);
  endproperty
  property p_rd_space;
    rd_rise |=> !rd_rise [*3];
  endproperty
  property p_wr_space;
    wr_rise |=> !wr_rise [*3];
  endproperty
  property p_stop_hold;
    k_still |=> $stable(q) && $stable(q_oe);
  endproperty
  property p_lock_wait;
    $rose(doff_n) |-> s_sel_idle;
  endproperty
  property p_doff_clk;
    $rose(doff_n) |-> !k_still && (k_n != k);
  endproperty
  property p_stop_idle;
    k_still && doff_n |-> r_n && w_n && !q_oe;
  endproperty
  a_rd_window: assert property (p_rd_window) else $error("read burst slots wrong");
  a_rd_only: assert property (p_rd_only) else $error("output driven without read");
  a_rd_space: assert property (p_rd_space) else $error("reads too close");
  a_wr_space: assert property (p_wr_space) else $error("writes too close");
  a_stop_hold: assert property (p_stop_hold) else $error("output moved without edge");
  a_lock_wait: assert property (p_lock_wait) else $error("select during lock wait");
  a_doff_clk: assert property (p_doff_clk) else $error("disable released on still clock");
  a_stop_idle: assert property (p_stop_idle) else $error("traffic while clock stopped");
endmodule

//--- verification/burst4_ddr_sram_port_and_dll_reset_test.sv
`timescale 1ns/1ps
module burst4_ddr_sram_port_and_dll_reset_test;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cmd_valid = 1'b0;
  logic        cmd_write = 1'b0;
  logic [7:0]  cmd_addr = 8'h00;
  logic        wd_valid = 1'b0;
  logic [35:0] wd_data = 36'h0;
  logic        relock = 1'b0;
  logic        rd_ready, wr_ready, wd_ready, rd_valid, ready, locked, rd_busy, wr_busy;
  logic [35:0] rd_data;
  logic [35:0] mem [256];
  logic [35:0] wq[$], rq[$], eq[$];
  int          errors = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          seq = 0;
  bqs_if link_if ();
  bqs_dev #(.LOCK_CYC(8)) bqs_dev_i (.LINK(link_if), .CORE_CLK(core_clk),
    .RST_N(rst_n), .LOCKED(locked), .RD_BUSY(rd_busy), .WR_BUSY(wr_busy));
  bqs_ctl #(.LOCK_CYC(8), .STABLE_CYC(2)) bqs_ctl_i (.LINK(link_if),
    .CORE_CLK(core_clk), .RST_N(rst_n), .CMD_VALID(cmd_valid), .CMD_WRITE(cmd_write),
    .CMD_ADDR(cmd_addr), .RD_READY(rd_ready), .WR_READY(wr_ready), .WD_VALID(wd_valid),
    .WD_DATA(wd_data), .WD_READY(wd_ready), .RD_DATA(rd_data), .RD_VALID(rd_valid),
    .RELOCK(relock), .READY(ready));
  bqs_sva bqs_sva_i (.CORE_CLK(core_clk), .RST_N(rst_n), .k(link_if.k),
    .k_n(link_if.k_n), .doff_n(link_if.doff_n), .r_n(link_if.r_n), .w_n(link_if.w_n),
    .a(link_if.a), .d(link_if.d), .q(link_if.q), .q_oe(link_if.q_oe));
  // ----------------------------------------
  // Clock, read capture and hang guard
  // ----------------------------------------
  always #20 core_clk = ~core_clk;
  // Read words are taken mid-cycle, well away from the edge that launches them.
  always @(negedge core_clk)
  begin
    if (rd_valid === 1'b1)
      rq.push_back(rd_data);
    cyc++;
    if (cyc == 3000)
    begin
      errors++;
      conclude();
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task chk(input logic [35:0] seen, input logic [35:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task conclude;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Waits on READY (sel 0) or LOCKED (sel 1) with a bound.
  task wait_sig(input int sel, input logic v, input int lim);
    int n;
    n = 0;
    while ((sel == 0 ? ready : locked) !== v && n < lim)
    begin
      tick(1);
      n++;
    end
    chk(sel == 0 ? ready : locked, v);
  endtask
  // Commands are held until the matching ready pulse; the model is updated at acceptance.
  task cmd(input logic wr, input logic [7:0] ad);
    int n;
    n = 0;
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_addr = ad;
    while ((wr ? wr_ready : rd_ready) !== 1'b1 && n < 200)
    begin
      tick(1);
      n++;
    end
    chk(n < 200, 1'b1);
    tick(1);
    cmd_valid = 1'b0;
    tick(1);
    for (int i = 0; i < 4; i++)
      if (wr)
        mem[ad + 8'(i)] = wq.pop_front();
      else
        eq.push_back(mem[ad + 8'(i)]);
  endtask
  task push(input int cnt, output int got);
    int w;
    got = 0;
    wd_valid = 1'b1;
    for (int i = 0; i < cnt; i++)
    begin
      wd_data = 36'hC00000000 | 36'(seq);
      w = 0;
      while (wd_ready !== 1'b1 && w < 6)
      begin
        tick(1);
        w++;
      end
      if (wd_ready !== 1'b1)
        break;
      tick(1);
      wq.push_back(wd_data);
      got++;
      seq++;
    end
    wd_valid = 1'b0;
  endtask
  task drain;
    int n;
    n = 0;
    while (rq.size() < eq.size() && n < 60)
    begin
      tick(1);
      n++;
    end
    chk(rq.size(), eq.size());
    while (eq.size() > 0 && rq.size() > 0)
      chk(rq.pop_front(), eq.pop_front());
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    int got;
    tick(20);
    rst_n = 1'b1;
    wait_sig(0, 1'b1, 2000);
    chk(locked, 1'b1);
    $display("test power_up done");
    push(9, got);
    chk(got, 8);
    cmd(1'b1, 8'hFE);
    cmd(1'b1, 8'h10);
    tick(12);
    chk(wd_ready, 1'b1);
    $display("test fifo_fill done");
    // The burst at FE wraps past the top of the address space.
    push(4, got);
    cmd(1'b0, 8'hFE);
    cmd(1'b1, 8'h20);
    tick(2);
    chk({rd_busy, wr_busy}, 2'b11);
    push(4, got);
    cmd(1'b0, 8'h10);
    cmd(1'b1, 8'h30);
    tick(12);
    cmd(1'b0, 8'hFE);
    cmd(1'b0, 8'h20);
    drain();
    $display("test bursts done");
    relock = 1'b1;
    tick(1);
    relock = 1'b0;
    wait_sig(1, 1'b0, 20);
    wait_sig(0, 1'b1, 400);
    chk(locked, 1'b1);
    cmd(1'b0, 8'h30);
    cmd(1'b0, 8'h10);
    drain();
    $display("test relock done");
    conclude();
  end
endmodule
